// *** rtl/rms_pkg.sv ***
// constants and types for the radio mode sequencer
package rms_pkg;
   localparam int CLK_HZ = 10_000_000;
   // tick times in nanoseconds
   localparam longint TICK1_NS = 64_000;
   localparam longint TICK2_NS = 4_100_000;
   localparam longint TICK3_NS = 262_000_000;
   localparam longint CLK_NS   = 1_000_000_000 / CLK_HZ;
   localparam int TICK1_CYC = int'(TICK1_NS / CLK_NS);
   localparam int TICK2_CYC = int'(TICK2_NS / CLK_NS);
   localparam int TICK3_CYC = int'(TICK3_NS / CLK_NS);
   localparam logic [1:0] TICK_OFF = 2'h0;

   // chip mode driven by the sequencer
   typedef enum logic [2:0] {
      RMS_MODE_SLEEP = 3'b000,
      RMS_MODE_STBY  = 3'b001,
      RMS_MODE_FS    = 3'b010,
      RMS_MODE_TX    = 3'b011,
      RMS_MODE_RX    = 3'b100
   } rms_mode_t;

   typedef enum logic [2:0] {
      RMS_OFF   = 3'b000,
      RMS_IDLE  = 3'b001,
      RMS_TX    = 3'b010,
      RMS_RX    = 3'b011,
      RMS_HELD  = 3'b100,
      RMS_WAITQ = 3'b101,
      RMS_FSHOP = 3'b110
   } rms_state_t;

   // settings written by the host
   typedef struct packed {
      logic       idle_lowpower_select;
      logic [1:0] start_exit_select;
      logic       low_power_choice;
      logic       idle_exit_select;
      logic       transmit_exit_select;
      logic [2:0] receive_exit_select;
      logic [1:0] timeout_exit_select;
      logic [2:0] packet_done_exit_select;
      logic       check_enable;
      logic       bad_check_autoflush;
   } rms_cfg_t;

   // packet-engine events, one-cycle pulses
   typedef struct packed {
      logic tx_complete_event;
      logic rx_payload_event;
      logic check_good_event;
      logic strength_event;
      logic sync_match_event;
      logic preamble_found_event;
      logic queue_level_event;
      logic queue_drained_event;
      logic strength_wait_timeout;
      logic preamble_wait_timeout;
      logic sync_wait_timeout;
   } rms_evt_t;
endpackage

// *** rtl/rms_sequencer.sv ***
// top-level radio mode sequencer with its two interval timers
`timescale 1ns/10ps
module rms_sequencer #(
   parameter int MULT_W    = 8,
   parameter int TICK1_LEN = rms_pkg::TICK1_CYC,
   parameter int TICK2_LEN = rms_pkg::TICK2_CYC,
   parameter int TICK3_LEN = rms_pkg::TICK3_CYC
) (
   input  wire logic               clk,
   input  wire logic               rst_b,
   input  wire rms_pkg::rms_cfg_t  cfg,
   input  wire rms_pkg::rms_evt_t  evt,
   input  wire logic               fsk_mode,
   input  wire logic               host_sleep,
   input  wire logic               seq_launch_cmd,
   input  wire logic               seq_stop_cmd,
   input  wire logic [1:0]         first_timer_tick,
   input  wire logic [1:0]         second_timer_tick,
   input  wire logic [MULT_W-1:0]  first_timer_multiplier,
   input  wire logic [MULT_W-1:0]  second_timer_multiplier,
   output rms_pkg::rms_mode_t      chip_mode,
   output logic                    seq_running,
   output logic                    rx_relaunch,
   output logic                    first_timer_event,
   output logic                    second_timer_event,
   output rms_pkg::rms_state_t     seq_state
);
   import rms_pkg::*;

   localparam int PRE_W = $clog2(TICK3_LEN + 1);

   // ==========================================================
   // timers
   // tick length for a resolution code, zero when disabled
   function automatic logic [PRE_W-1:0] tick_len(input logic [1:0] sel);
      logic [PRE_W-1:0] r;
      r = '0;
      if (sel == 2'h1) begin
         r = PRE_W'(TICK1_LEN);
      end else if (sel == 2'h2) begin
         r = PRE_W'(TICK2_LEN);
      end else if (sel == 2'h3) begin
         r = PRE_W'(TICK3_LEN);
      end
      return r;
   endfunction

   logic              active_q, active_d;   // 0: first timer, 1: second
   logic              armed_q, armed_d;
   logic [PRE_W-1:0]  pre_q, pre_d;
   logic [MULT_W-1:0] cnt_q, cnt_d;
   logic              ev1_q, ev1_d, ev2_q, ev2_d;
   logic              launch;
   logic [1:0]        cur_tick;
   logic [MULT_W-1:0] cur_mult;

   assign launch   = seq_launch_cmd && !seq_stop_cmd && fsk_mode;
   assign cur_tick = active_q ? second_timer_tick : first_timer_tick;
   assign cur_mult = active_q ? second_timer_multiplier
                              : first_timer_multiplier;

   // alternating chain, independent of the sequencer state
   always_comb begin
      active_d = active_q;
      armed_d  = armed_q;
      pre_d    = pre_q;
      cnt_d    = cnt_q;
      ev1_d    = 1'b0;
      ev2_d    = 1'b0;
      if (seq_stop_cmd || !fsk_mode) begin
         armed_d = 1'b0;
      end else if (launch) begin
         active_d = 1'b0;
         armed_d  = (first_timer_tick != TICK_OFF)
                    && (first_timer_multiplier != '0);
         pre_d    = tick_len(first_timer_tick);
         cnt_d    = first_timer_multiplier;
      end else if (armed_q) begin
         if (cur_tick == TICK_OFF) begin
            armed_d = 1'b0;
         end else if (pre_q > PRE_W'(1)) begin
            pre_d = pre_q - PRE_W'(1);
         end else begin
            pre_d = tick_len(cur_tick);
            if (cnt_q > MULT_W'(1)) begin
               cnt_d = cnt_q - MULT_W'(1);
            end else begin
               // expiry hands over to the other timer
               ev1_d    = !active_q;
               ev2_d    = active_q;
               active_d = !active_q;
               // second follows first; first follows second
               pre_d    = tick_len(active_q ? first_timer_tick
                                            : second_timer_tick);
               cnt_d    = active_q ? first_timer_multiplier
                                   : second_timer_multiplier;
               // disabled next timer breaks the chain
               // zero multiplier disarms too, as it does at launch
               armed_d  = ((active_q ? first_timer_tick
                                     : second_timer_tick) != TICK_OFF)
                          && ((active_q ? first_timer_multiplier
                                        : second_timer_multiplier) != '0);
            end
         end
      end
   end

   // timer registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         active_q <= 1'b0;
         armed_q  <= 1'b0;
         pre_q    <= '0;
         cnt_q    <= '0;
         ev1_q    <= 1'b0;
         ev2_q    <= 1'b0;
      end else begin
         active_q <= active_d;
         armed_q  <= armed_d;
         pre_q    <= pre_d;
         cnt_q    <= cnt_d;
         ev1_q    <= ev1_d;
         ev2_q    <= ev2_d;
      end
   end

   assign first_timer_event  = ev1_q;
   assign second_timer_event = ev2_q;

   // ==========================================================
   // state machine
   rms_state_t st_q, st_d;
   logic       init_sleep_q, init_sleep_d;
   logic       relaunch_q, relaunch_d;
   logic       rx_timeout, bad_check;
   rms_state_t lp_state;

   assign rx_timeout = evt.strength_wait_timeout
                       || evt.preamble_wait_timeout
                       || evt.sync_wait_timeout;
   // payload with bad check acts as timeout
   assign bad_check = cfg.receive_exit_select == 3'h3 && cfg.check_enable
                      && !cfg.bad_check_autoflush && evt.rx_payload_event
                      && !evt.check_good_event;
   assign lp_state = cfg.low_power_choice ? RMS_IDLE : RMS_OFF;

   always_comb begin
      st_d         = st_q;
      init_sleep_d = init_sleep_q;
      relaunch_d   = 1'b0;
      // stop wins at any time; only in fsk/ook
      if (seq_stop_cmd || !fsk_mode) begin
         st_d = RMS_OFF;
      end else begin
         case (st_q)
            RMS_OFF: begin
               if (launch) begin
                  init_sleep_d = host_sleep;
                  case (cfg.start_exit_select)
                     2'h0: st_d = lp_state;
                     2'h1: st_d = RMS_RX;
                     2'h2: st_d = RMS_TX;
                     default: st_d = RMS_WAITQ;
                  endcase
               end
            end
            RMS_WAITQ: begin
               if (evt.queue_level_event) begin
                  st_d = RMS_TX;
               end
            end
            RMS_IDLE: begin
               if (ev1_q) begin
                  st_d = cfg.idle_exit_select ? RMS_RX : RMS_TX;
               end
            end
            RMS_TX: begin
               if (evt.tx_complete_event) begin
                  st_d = cfg.transmit_exit_select ? RMS_RX : lp_state;
               end
            end
            RMS_RX: begin
               if (ev2_q) begin
                  st_d = lp_state;
               end else if (rx_timeout || bad_check) begin
                  case (cfg.timeout_exit_select)
                     2'h0: relaunch_d = 1'b1;
                     2'h1: st_d = RMS_TX;
                     2'h2: st_d = lp_state;
                     default: st_d = RMS_OFF;
                  endcase
               end else begin
                  case (cfg.receive_exit_select)
                     3'h1: if (evt.rx_payload_event) st_d = RMS_HELD;
                     3'h2: if (evt.rx_payload_event) st_d = lp_state;
                     3'h3: if (evt.check_good_event) st_d = RMS_HELD;
                     3'h4: if (evt.strength_event) st_d = RMS_OFF;
                     3'h5: if (evt.sync_match_event) st_d = RMS_OFF;
                     3'h6: if (evt.preamble_found_event) st_d = RMS_OFF;
                     default: st_d = st_q;
                  endcase
               end
            end
            RMS_HELD: begin
               case (cfg.packet_done_exit_select)
                  3'h0: st_d = RMS_OFF;
                  3'h1: if (evt.queue_drained_event) st_d = RMS_TX;
                  3'h2: st_d = lp_state;
                  3'h3: st_d = RMS_FSHOP;
                  3'h4: st_d = RMS_RX;
                  default: st_d = st_q;
               endcase
            end
            RMS_FSHOP: st_d = RMS_RX;   // one cycle in fs for relock
            default: st_d = RMS_OFF;
         endcase
      end
   end

   // state registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q         <= RMS_OFF;
         init_sleep_q <= 1'b0;
         relaunch_q   <= 1'b0;
      end else begin
         st_q         <= st_d;
         init_sleep_q <= init_sleep_d;
         relaunch_q   <= relaunch_d;
      end
   end

   // ==========================================================
   // chip mode from state
   always_comb begin
      case (st_q)
         // off restores initial mode; idle mode select
         RMS_OFF: chip_mode = init_sleep_q ? RMS_MODE_SLEEP : RMS_MODE_STBY;
         RMS_IDLE: chip_mode = cfg.idle_lowpower_select ? RMS_MODE_SLEEP
                                                        : RMS_MODE_STBY;
         RMS_WAITQ: chip_mode = init_sleep_q ? RMS_MODE_SLEEP
                                             : RMS_MODE_STBY;
         RMS_TX: chip_mode = RMS_MODE_TX;
         RMS_FSHOP: chip_mode = RMS_MODE_FS;
         default: chip_mode = RMS_MODE_RX;
      endcase
   end

   assign seq_running = st_q != RMS_OFF;
   assign rx_relaunch = relaunch_q;
   assign seq_state   = st_q;

   // ==========================================================
   // checks
   // stop forces off
   AST_STOP_OFF: assert property (@(posedge clk) disable iff (!rst_b)
      seq_stop_cmd |=> st_q == RMS_OFF) else $error("stop not honoured");
   // idle waits only for first timer
   AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
      st_q == RMS_IDLE && !ev1_q && !seq_stop_cmd && fsk_mode
      |=> st_q == RMS_IDLE) else $error("idle left without timer");
   AST_IDLE_EXIT: assert property (@(posedge clk) disable iff (!rst_b)
      st_q == RMS_IDLE && ev1_q && !seq_stop_cmd && fsk_mode
      |=> st_q == (cfg.idle_exit_select ? RMS_RX : RMS_TX))
      else $error("wrong idle exit");
   AST_RX_T2: assert property (@(posedge clk) disable iff (!rst_b)
      st_q == RMS_RX && ev2_q && !seq_stop_cmd && fsk_mode
      |=> st_q != RMS_RX) else $error("rx kept on second timer");
   AST_IDLE_MODE: assert property (@(posedge clk) disable iff (!rst_b)
      st_q == RMS_IDLE |-> chip_mode == (cfg.idle_lowpower_select
      ? RMS_MODE_SLEEP : RMS_MODE_STBY)) else $error("bad idle mode");
   AST_EV_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
      ev1_q |=> !ev1_q && !ev2_q) else $error("event not a pulse");
   // second event not within the two cycles after first
   AST_CHAIN: assert property (@(posedge clk) disable iff (!rst_b)
      ev1_q |-> ##1 !ev2_q [*2]) else $error("second timer too early");
   AST_TX_EXIT: assert property (@(posedge clk) disable iff (!rst_b)
      st_q == RMS_TX && evt.tx_complete_event && cfg.transmit_exit_select
      && !seq_stop_cmd && fsk_mode |=> st_q == RMS_RX)
      else $error("wrong tx exit");
   COV_START: cover property (@(posedge clk) launch ##1 seq_running);
   COV_IDLE_RX: cover property (@(posedge clk)
      st_q == RMS_IDLE ##1 st_q == RMS_RX);
   COV_HELD: cover property (@(posedge clk) st_q == RMS_HELD);
endmodule

// *** verification/rms_host_model.sv ***
// host model: sequencer settings, timer setup and commands
`timescale 1ns/10ps
module rms_host_model (
   input  wire logic         clk,
   output rms_pkg::rms_cfg_t cfg,
   output logic              host_sleep,
   output logic              seq_launch_cmd,
   output logic              seq_stop_cmd,
   output logic [1:0]        first_timer_tick,
   output logic [1:0]        second_timer_tick,
   output logic [7:0]        first_timer_multiplier,
   output logic [7:0]        second_timer_multiplier
);
   import rms_pkg::*;

   // ====================
   // quiet host after power-up
   initial begin
      cfg = '0;
      host_sleep = 1'b0;
      seq_launch_cmd = 1'b0;
      seq_stop_cmd = 1'b0;
      first_timer_tick = 2'h0;
      second_timer_tick = 2'h0;
      first_timer_multiplier = 8'h0;
      second_timer_multiplier = 8'h0;
   end

   // settings move off the sampling edge
   task automatic setup(input rms_cfg_t c, input logic sl);
      @(negedge clk);
      cfg        = c;
      host_sleep = sl;
   endtask

   task automatic timers(input logic [1:0] t1, input logic [1:0] t2,
                         input logic [7:0] m1, input logic [7:0] m2);
      @(negedge clk);
      first_timer_tick        = t1;
      second_timer_tick       = t2;
      first_timer_multiplier  = m1;
      second_timer_multiplier = m2;
   endtask

   // stop any time, never with launch
   task automatic command(input logic go);
      @(negedge clk);
      seq_launch_cmd = go;
      seq_stop_cmd   = ~go;
      @(negedge clk);
      seq_launch_cmd = 1'b0;
      seq_stop_cmd   = 1'b0;
   endtask
endmodule

// *** verification/rms_sequencer_tb_top.sv ***
// self-checking bench for the radio mode sequencer
`timescale 1ns/10ps
module rms_sequencer_tb_top;
   import rms_pkg::*;
   // short ticks keep the run brief
   localparam int L1 = 4;
   localparam int L2 = 8;
   localparam int L3 = 16;
   logic               clk = 1'b0;
   logic               rst_b = 1'b0;
   logic               fsk_mode = 1'b1;
   rms_evt_t           evt = '0;
   rms_cfg_t           cfg;
   logic               host_sleep, seq_launch_cmd, seq_stop_cmd;
   logic [1:0]         first_timer_tick, second_timer_tick;
   logic [7:0]         first_timer_multiplier, second_timer_multiplier;
   rms_mode_t          chip_mode;
   rms_state_t         seq_state;
   rms_state_t         prev = RMS_OFF;
   logic               seq_running, rx_relaunch;
   logic               first_timer_event, second_timer_event;
   int                 err_total = 0;
   int                 check_count = 0;
   int                 relaunch_cnt = 0;
   logic [31:0]        rng = 32'h4dedf3bf;
   logic [5:0]         notes[$];

   always #50 clk = ~clk;

   rms_sequencer #(.TICK1_LEN(L1), .TICK2_LEN(L2), .TICK3_LEN(L3)) uut (
      .clk, .rst_b, .cfg, .evt, .fsk_mode, .host_sleep, .seq_launch_cmd,
      .seq_stop_cmd, .first_timer_tick, .second_timer_tick,
      .first_timer_multiplier, .second_timer_multiplier, .chip_mode,
      .seq_running, .rx_relaunch, .first_timer_event, .second_timer_event,
      .seq_state);

   rms_host_model host (
      .clk, .cfg, .host_sleep, .seq_launch_cmd, .seq_stop_cmd,
      .first_timer_tick, .second_timer_tick, .first_timer_multiplier,
      .second_timer_multiplier);

   // ====================
   // helpers
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // state and chip mode travel as one note
   task automatic chk_note(input logic [5:0] got, input logic [5:0] exp);
      chk_val({26'h0, got}, {26'h0, exp});
   endtask

   task automatic note(input rms_state_t s, input rms_mode_t m);
      notes.push_back({s, m});
   endtask

   task automatic pulse(input logic [10:0] e);
      @(negedge clk);
      evt = e;
      @(negedge clk);
      evt = '0;
   endtask

   // a hang here would stall the run, so it is cut short
   task automatic wait_for(input rms_state_t s);
      int n;
      n = 0;
      while (seq_state !== s && n < 300) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 300) begin
         err_total++;
         finish_test();
      end
   endtask

   // cycles from now until a timer pulse, capped by bound
   task automatic time_evt(input logic sec, input int bound, output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while ((sec ? second_timer_event : first_timer_event) !== 1'b1
                 && n < bound);
      if (n == 500) begin
         err_total++;
         finish_test();
      end
   endtask

   // ====================
   // watcher: every state change takes the oldest note
   always @(posedge clk) begin
      #1;
      if (rst_b === 1'b1 && seq_state !== prev)
         chk_note({seq_state, chip_mode}, notes.size() ? notes.pop_front() : 6'h3f);
      prev = seq_state;
      relaunch_cnt += int'(rx_relaunch === 1'b1);
   end

   // ====================
   // main sequence
   initial begin
      int n;
      int m;
      int lk;
      logic [31:0] r;
      rms_mode_t init;
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
      chk_note({seq_state, chip_mode}, {RMS_OFF, RMS_MODE_STBY});
      // test 1: tick codes, timer chain, second timer leaves rx
      for (int k = 0; k < 4; k++) begin
         r = rnd();
         m = 1 + int'(r[7:0] % 3);
         lk = (k == 1) ? L1 : (k == 2) ? L2 : L3;
         init = r[8] ? RMS_MODE_SLEEP : RMS_MODE_STBY;
         host.setup('{start_exit_select: 2'h1, default: '0}, r[8]);
         host.timers(k[1:0], 2'h1, m[7:0], 8'h1);
         note(RMS_RX, RMS_MODE_RX);
         note(RMS_OFF, init);
         host.command(1'b1);
         time_evt(1'b0, k ? 500 : 60, n);
         chk_val(n, k ? lk * m : 60);
         if (k != 0) begin
            time_evt(1'b1, 500, n);
            chk_val(n, L1);
         end else
            host.command(1'b0);
         wait_for(RMS_OFF);
      end
      host.timers(2'h0, 2'h0, 8'h0, 8'h0);
      $display("test 1 done");
      // test 2: held exit codes 0, 1, 3 and 4, off restores sleep
      for (int j = 0; j < 4; j++) begin
         lk = (j > 1) ? j + 1 : j;
         host.setup('{start_exit_select: 2'h1, receive_exit_select: 3'h1,
                      packet_done_exit_select: 3'(lk), default: '0}, 1'b1);
         note(RMS_RX, RMS_MODE_RX);
         note(RMS_HELD, RMS_MODE_RX);
         if (lk == 1) note(RMS_TX, RMS_MODE_TX);
         if (lk == 3) note(RMS_FSHOP, RMS_MODE_FS);
         if (lk >= 3) note(RMS_RX, RMS_MODE_RX);
         note(RMS_OFF, RMS_MODE_SLEEP);
         host.command(1'b1);
         pulse(11'h200);
         pulse(11'h008);
         if (lk != 0) host.command(1'b0);
         wait_for(RMS_OFF);
      end
      $display("test 2 done");
      // test 3: tx, rx, bad check, held, idle ignoring events
      host.setup('{idle_lowpower_select: 1'b1, start_exit_select: 2'h2,
                   low_power_choice: 1'b1, transmit_exit_select: 1'b1,
                   receive_exit_select: 3'h3, timeout_exit_select: 2'h1,
                   packet_done_exit_select: 3'h2, check_enable: 1'b1,
                   default: '0}, 1'b0);
      note(RMS_TX, RMS_MODE_TX);
      note(RMS_RX, RMS_MODE_RX);
      note(RMS_TX, RMS_MODE_TX);
      note(RMS_RX, RMS_MODE_RX);
      note(RMS_HELD, RMS_MODE_RX);
      note(RMS_IDLE, RMS_MODE_SLEEP);
      note(RMS_OFF, RMS_MODE_STBY);
      host.command(1'b1);
      pulse(11'h400);
      pulse(11'h200);
      pulse(11'h400);
      pulse(11'h300);
      wait_for(RMS_IDLE);
      pulse(11'h7ff);
      r = rnd();
      pulse(r[10:0]);
      host.command(1'b0);
      wait_for(RMS_OFF);
      $display("test 3 done");
      // test 4: off on rx events and on each receive timeout
      for (int i = 0; i < 6; i++) begin
         host.setup('{start_exit_select: 2'h1, timeout_exit_select: 2'h3,
                      receive_exit_select: (i < 3) ? 3'(4 + i) : 3'h0,
                      default: '0}, 1'b0);
         note(RMS_RX, RMS_MODE_RX);
         note(RMS_OFF, RMS_MODE_STBY);
         host.command(1'b1);
         pulse(11'h1 << ((i < 3) ? 7 - i : 5 - i));
         wait_for(RMS_OFF);
      end
      $display("test 4 done");
      // test 5: launch waits for queue level
      host.setup('{start_exit_select: 2'h3, default: '0}, 1'b0);
      note(RMS_WAITQ, RMS_MODE_STBY);
      note(RMS_TX, RMS_MODE_TX);
      note(RMS_OFF, RMS_MODE_STBY);
      host.command(1'b1);
      pulse(11'h010);
      host.command(1'b0);
      wait_for(RMS_OFF);
      $display("test 5 done");
      // test 6: timeout relaunch, then modem mode change
      host.setup('{start_exit_select: 2'h1, default: '0}, 1'b0);
      note(RMS_RX, RMS_MODE_RX);
      host.command(1'b1);
      chk_val(seq_running, 1);
      m = relaunch_cnt;
      pulse(11'h004);
      chk_val(relaunch_cnt - m, 1);
      note(RMS_OFF, RMS_MODE_STBY);
      @(negedge clk);
      fsk_mode = 1'b0;
      wait_for(RMS_OFF);
      chk_val(seq_running, 0);
      @(negedge clk);
      fsk_mode = 1'b1;
      $display("test 6 done");
      // test 7: idle via low-power choice, first timer exits to tx
      // settings that this path never consults are random, as are idle_lowpower_select and host_sleep
      r = rnd();
      host.setup('{idle_lowpower_select: r[0], low_power_choice: 1'b1,
                   transmit_exit_select: r[1], receive_exit_select: r[4:2],
                   timeout_exit_select: r[6:5],
                   packet_done_exit_select: r[9:7], check_enable: r[10],
                   bad_check_autoflush: r[11], default: '0}, r[12]);
      host.timers(2'h1, 2'h1, 8'h2, 8'h8);
      note(RMS_IDLE, r[0] ? RMS_MODE_SLEEP : RMS_MODE_STBY);
      note(RMS_TX, RMS_MODE_TX);
      note(RMS_OFF, r[12] ? RMS_MODE_SLEEP : RMS_MODE_STBY);
      host.command(1'b1);
      wait_for(RMS_TX);
      host.command(1'b0);
      wait_for(RMS_OFF);
      $display("test 7 done");
      repeat (3) @(negedge clk);
      chk_val(notes.size(), 0);
      finish_test();
   end
endmodule
